// ===== ptm_pkg.sv
// Shared constants and carrier types for the prescaled overflow timer.
// Assumes a single 40 MHz clock and an AXI4-Lite register port.
package ptm_pkg;
    localparam int unsigned CLK_HZ = 40_000_000;
    // Instruction clock is the system clock divided by four.
    localparam int unsigned INSTR_DIV = 4;
    localparam logic [1:0] DIV_LAST = 2'(INSTR_DIV - 1);
    localparam int unsigned ADDR_W = 10;
    // Register indices; the byte address is four times the index.
    localparam logic [7:0] IDX_CTRL = 8'h05;
    localparam logic [7:0] IDX_STAT = 8'h07;
    localparam logic [7:0] IDX_CNT_LO = 8'h0b;
    localparam logic [7:0] IDX_CNT_HI = 8'h0c;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] CTRL_WMASK = 8'hfe;
    localparam int unsigned STAT_OVF_EN = 0;
    localparam int unsigned STAT_EXT_EN = 1;
    localparam int unsigned STAT_OVF_FLAG = 4;
    localparam int unsigned STAT_EXT_FLAG = 5;
    localparam int unsigned PS_TOP = 3;
    localparam logic [7:0] PS_FULL = 8'hff;
    localparam logic [7:0] BYTE_MAX = 8'hff;
    localparam logic [15:0] CNT_MAX = 16'hffff;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic ext_irq_edge_select;
        logic count_edge_select;
        logic count_source_select;
        logic [3:0] prescale_field;
        logic unused0;
    } ptm_ctrl_t;

    typedef struct packed {
        logic awvalid;
        logic [ADDR_W-1:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [ADDR_W-1:0] araddr;
        logic rready;
    } ptm_axi_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } ptm_axi_rsp_t;
endpackage : ptm_pkg

// ===== ptm_prescaler.sv
// Eight-bit event prescaler with ratios 1:1 to 1:256.
// Assumes in_event is a one-cycle pulse in the clk domain.
`timescale 1ns/10ps
module ptm_prescaler import ptm_pkg::*; (
    input wire logic clk,
    input wire logic resetn,
    input wire logic in_event,
    input wire logic clear,
    input wire logic [3:0] ratio_code,
    output logic tick
);
    typedef struct packed {
        logic [7:0] cnt;
        logic tick;
    } ptm_ps_state_t;

    ptm_ps_state_t st_r;
    ptm_ps_state_t st_nxt;
    logic [7:0] limit;

    always_comb begin
        // Top code bit forces the full ratio.
        limit = ratio_code[PS_TOP] ? PS_FULL :
            (8'h01 << ratio_code[2:0]) - 8'h01;
        st_nxt = st_r;
        st_nxt.tick = 1'b0;
        if (clear) begin
            st_nxt.cnt = '0;
        end else if (in_event) begin
            // A ratio lowered on the fly wraps at once, not after 256.
            if (st_r.cnt >= limit) begin
                st_nxt.cnt = '0;
                st_nxt.tick = 1'b1;
            end else begin
                st_nxt.cnt = st_r.cnt + 8'h01;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign tick = st_r.tick;

    AST_PS_CLEAR: assert property (@(posedge clk) disable iff (!resetn)
        clear |=> !tick && st_r.cnt == 8'h00)
        else $error("prescaler not cleared");
    // Every counted event at the full ratio ticks exactly when the
    // count stood at its top, so an early or missing wrap both fail.
    AST_PS_FULL: assert property (@(posedge clk) disable iff (!resetn)
        ratio_code[PS_TOP] && in_event && !clear
        |=> tick == ($past(st_r.cnt) == PS_FULL))
        else $error("full ratio tick wrong");
endmodule : ptm_prescaler

// ===== ptm_timer.sv
// Prescaled 16-bit overflow timer with AXI4-Lite register slave.
// Assumes count and irq pins are synchronous to clk.
`timescale 1ns/10ps
module ptm_timer import ptm_pkg::*; (
    input wire logic clk,
    input wire logic resetn,
    input wire ptm_axi_req_t axi_req,
    output ptm_axi_rsp_t axi_rsp,
    input wire logic external_count_pin,
    input wire logic external_irq_pin,
    input wire logic overflow_irq_ack,
    output logic irq
);
    typedef struct packed {
        ptm_ctrl_t ctrl;
        logic [15:0] cnt;
        logic inh_lo;
        logic inh_hi;
        logic [1:0] div;
        logic cpin_prev;
        logic ipin_prev;
        logic ps_tog;
        logic sync1;
        logic sync2;
        logic sync3;
        logic ovf_flag;
        logic ovf_en;
        logic ext_flag;
        logic ext_en;
        logic aw_have;
        logic [7:0] aw_idx;
        logic w_have;
        logic [7:0] wdata;
        logic wstrb0;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [7:0] rdata;
        logic [1:0] rresp;
        logic rd_ctrl;
    } ptm_state_t;

    ptm_state_t s_r;
    ptm_state_t s_nxt;
    logic ps_tick;
    logic src_event;
    logic ps_clear;
    logic sync_edge;
    logic inc_lo;
    logic inc_hi;
    logic wrap;
    logic ext_set;
    logic wr_fire;
    logic wr_lo;
    logic wr_hi;
    logic [7:0] rd_idx;
    logic [7:0] stat_rd;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    ptm_prescaler u_ps (
        .clk(clk),
        .resetn(resetn),
        .in_event(src_event),
        .clear(ps_clear),
        .ratio_code(s_r.ctrl.prescale_field),
        .tick(ps_tick)
    );

    always_comb begin
        s_nxt = s_r;
        axi_rsp.awready = !s_r.aw_have && !s_r.bvalid;
        axi_rsp.wready = !s_r.w_have && !s_r.bvalid;
        axi_rsp.arready = !s_r.rvalid;
        axi_rsp.bvalid = s_r.bvalid;
        axi_rsp.bresp = s_r.bresp;
        axi_rsp.rvalid = s_r.rvalid;
        axi_rsp.rdata = {24'h000000, s_r.rdata};
        axi_rsp.rresp = s_r.rresp;

        wr_fire = s_r.aw_have && s_r.w_have && !s_r.bvalid;
        wr_lo = wr_fire && s_r.wstrb0 && s_r.aw_idx == IDX_CNT_LO;
        wr_hi = wr_fire && s_r.wstrb0 && s_r.aw_idx == IDX_CNT_HI;
        ps_clear = wr_lo || wr_hi;

        // Event source ahead of the prescaler.
        s_nxt.div = s_r.div + 2'h1;
        s_nxt.cpin_prev = external_count_pin;
        if (s_r.ctrl.count_source_select) begin
            src_event = s_r.div == DIV_LAST;
        end else if (s_r.ctrl.count_edge_select) begin
            src_event = external_count_pin && !s_r.cpin_prev;
        end else begin
            src_event = !external_count_pin && s_r.cpin_prev;
        end

        // The prescaler output is a toggle resynchronised before use,
        // so a fast pin never has to be seen edge by edge here.
        s_nxt.ps_tog = s_r.ps_tog ^ ps_tick;
        s_nxt.sync1 = s_r.ps_tog;
        s_nxt.sync2 = s_r.sync1;
        s_nxt.sync3 = s_r.sync2;
        sync_edge = s_r.sync2 ^ s_r.sync3;

        // A freshly written half skips one increment; the carry into
        // the high half is lost when the high half is stalled.
        inc_lo = sync_edge && !s_r.inh_lo;
        inc_hi = inc_lo && s_r.cnt[7:0] == BYTE_MAX && !s_r.inh_hi;
        wrap = inc_hi && s_r.cnt == CNT_MAX;
        if (wr_lo) begin
            s_nxt.cnt[7:0] = s_r.wdata;
        end else if (inc_lo) begin
            s_nxt.cnt[7:0] = s_r.cnt[7:0] + 8'h01;
        end
        if (wr_hi) begin
            s_nxt.cnt[15:8] = s_r.wdata;
        end else if (inc_hi) begin
            s_nxt.cnt[15:8] = s_r.cnt[15:8] + 8'h01;
        end
        s_nxt.inh_lo = wr_lo;
        s_nxt.inh_hi = wr_hi;

        s_nxt.ipin_prev = external_irq_pin;
        ext_set = s_r.ctrl.ext_irq_edge_select ?
            (external_irq_pin && !s_r.ipin_prev) :
            (!external_irq_pin && s_r.ipin_prev);

        if (wr_fire && s_r.wstrb0 && s_r.aw_idx == IDX_CTRL) begin
            s_nxt.ctrl = ptm_ctrl_t'(s_r.wdata & CTRL_WMASK);
        end
        if (wr_fire && s_r.wstrb0 && s_r.aw_idx == IDX_STAT) begin
            s_nxt.ovf_en = s_r.wdata[STAT_OVF_EN];
            s_nxt.ext_en = s_r.wdata[STAT_EXT_EN];
            s_nxt.ovf_flag = s_r.ovf_flag && !s_r.wdata[STAT_OVF_FLAG];
            s_nxt.ext_flag = s_r.ext_flag && !s_r.wdata[STAT_EXT_FLAG];
        end
        if (overflow_irq_ack) begin
            s_nxt.ovf_flag = 1'b0;
        end
        // A new event outranks any clear in the same cycle.
        if (wrap) begin
            s_nxt.ovf_flag = 1'b1;
        end
        if (ext_set) begin
            s_nxt.ext_flag = 1'b1;
        end

        // Write channels are taken independently, answered together.
        if (axi_req.awvalid && axi_rsp.awready) begin
            s_nxt.aw_have = 1'b1;
            s_nxt.aw_idx = axi_req.awaddr[ADDR_W-1:2];
        end
        if (axi_req.wvalid && axi_rsp.wready) begin
            s_nxt.w_have = 1'b1;
            s_nxt.wdata = axi_req.wdata[7:0];
            s_nxt.wstrb0 = axi_req.wstrb[0];
        end
        if (wr_fire) begin
            s_nxt.aw_have = 1'b0;
            s_nxt.w_have = 1'b0;
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp = (s_r.aw_idx == IDX_CTRL ||
                s_r.aw_idx == IDX_STAT || s_r.aw_idx == IDX_CNT_LO ||
                s_r.aw_idx == IDX_CNT_HI) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_r.bvalid && axi_req.bready) begin
            s_nxt.bvalid = 1'b0;
        end

        rd_idx = axi_req.araddr[ADDR_W-1:2];
        stat_rd = '0;
        stat_rd[STAT_OVF_EN] = s_r.ovf_en;
        stat_rd[STAT_EXT_EN] = s_r.ext_en;
        stat_rd[STAT_OVF_FLAG] = s_r.ovf_flag;
        stat_rd[STAT_EXT_FLAG] = s_r.ext_flag;
        if (axi_req.arvalid && axi_rsp.arready) begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rresp = RESP_OKAY;
            s_nxt.rd_ctrl = rd_idx == IDX_CTRL;
            case (rd_idx)
                IDX_CTRL: s_nxt.rdata = s_r.ctrl & CTRL_WMASK;
                IDX_STAT: s_nxt.rdata = stat_rd;
                IDX_CNT_LO: s_nxt.rdata = s_r.cnt[7:0];
                IDX_CNT_HI: s_nxt.rdata = s_r.cnt[15:8];
                default: begin
                    s_nxt.rdata = '0;
                    s_nxt.rresp = RESP_SLVERR;
                end
            endcase
        end else if (s_r.rvalid && axi_req.rready) begin
            s_nxt.rvalid = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            s_r <= '0; // Control register resets to its zero value.
        end else begin
            s_r <= s_nxt;
        end
    end

    assign irq = (s_r.ovf_flag && s_r.ovf_en) ||
        (s_r.ext_flag && s_r.ext_en);

    AST_CTRL_BIT0: assert property (s_r.rvalid && s_r.rd_ctrl
        |-> s_r.rdata[0] == 1'b0)
        else $error("control bit 0 read as one");
    AST_WRAP: assert property (sync_edge && s_r.cnt == CNT_MAX &&
        !s_r.inh_lo && !s_r.inh_hi && !ps_clear
        |=> s_r.cnt == 16'h0000 && s_r.ovf_flag)
        else $error("wrap did not set overflow flag");
    AST_SYNC_ONLY: assert property (!sync_edge && !ps_clear
        |=> $stable(s_r.cnt))
        else $error("count moved without synchronised edge");
    AST_SYNC_DELAY: assert property (ps_tick |-> ##3 sync_edge)
        else $error("prescaler output not seen three cycles later");
    AST_LO_STALL: assert property (wr_lo ##1 !ps_clear
        |=> s_r.cnt[7:0] == $past(s_r.wdata, 2))
        else $error("written low byte incremented");
    // Internal events must come exactly every fourth clock.
    AST_INTERNAL: assert property (s_r.ctrl.count_source_select &&
        src_event ##1 s_r.ctrl.count_source_select [*4]
        |-> src_event && !$past(src_event) && !$past(src_event, 2) &&
        !$past(src_event, 3))
        else $error("internal source event off the instruction clock");
    AST_EXT_EDGE: assert property (!s_r.ctrl.count_source_select &&
        $rose(external_count_pin) |-> src_event ==
        s_r.ctrl.count_edge_select)
        else $error("count pin edge selection wrong");
    AST_EXT_IRQ: assert property (s_r.ctrl.ext_irq_edge_select &&
        $rose(external_irq_pin) |=> s_r.ext_flag)
        else $error("irq pin rising edge missed");
    AST_MASK: assert property (!s_r.ovf_en && !s_r.ext_en
        |-> !irq)
        else $error("masked request reached irq");
    AST_ACK: assert property (overflow_irq_ack && !wrap
        |=> !s_r.ovf_flag)
        else $error("acknowledge did not clear overflow flag");
    AST_BHOLD: assert property (s_r.bvalid && !axi_req.bready
        |=> s_r.bvalid && $stable(s_r.bresp))
        else $error("write response dropped early");

    COV_WRAP: cover property (wrap ##1 irq);
    COV_EXT_COUNT: cover property (!s_r.ctrl.count_source_select &&
        sync_edge);
    COV_EXT_IRQ: cover property (ext_set ##1 irq);
endmodule : ptm_timer

// ===== ptm_pin_src.sv
// Behavioural source for the external count pin.
// Assumes the pin is sampled on the rising edge of clk.
`timescale 1ns/10ps
module ptm_pin_src (
    input wire logic clk,
    output logic pin
);
    // A gated counting clock: it stands low between bursts.
    initial pin = 1'b0;

    // The hold argument sets how slowly the source toggles.
    task automatic burst(input int n, input int hold);
        repeat (n) begin
            repeat (hold) @(posedge clk);
            pin <= 1'b1;
            repeat (hold) @(posedge clk);
            pin <= 1'b0;
        end
    endtask : burst
endmodule : ptm_pin_src

// ===== test_prescaled_16bit_overflow_timer.sv
// Self-checking bench for the prescaled overflow timer.
// Assumes the pin source model and the design package.
`timescale 1ns/10ps
module test_prescaled_16bit_overflow_timer import ptm_pkg::*; ;
    localparam logic [9:0] AC = {IDX_CTRL, 2'b00};
    localparam logic [9:0] AS = {IDX_STAT, 2'b00};
    localparam logic [9:0] AL = {IDX_CNT_LO, 2'b00};
    localparam logic [9:0] AH = {IDX_CNT_HI, 2'b00};
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic eirq = 1'b0;
    logic ack = 1'b0;
    ptm_axi_req_t rq = '0;
    ptm_axi_rsp_t rs;
    logic cpin;
    logic irq;
    logic [31:0] d;
    logic [1:0] r;
    logic [3:0] cd [10] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 15};
    int n_mismatch = 0;
    int checks = 0;
    int cyc = 0;

    ptm_timer dut (.clk(clk), .resetn(resetn), .axi_req(rq),
        .axi_rsp(rs), .external_count_pin(cpin),
        .external_irq_pin(eirq), .overflow_irq_ack(ack), .irq(irq));
    ptm_pin_src src (.clk(clk), .pin(cpin));

    initial forever #12.5 clk = ~clk;

    task automatic final_report;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : final_report

    // The longest test is the 1:256 rate pair, about 16k cycles.
    always @(posedge clk) begin
        cyc++;
        if (cyc == 60000) begin
            n_mismatch++;
            final_report();
        end
    end

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
        end
    endtask : chk

    task automatic chk_rng(input logic [31:0] g, lo, hi);
        checks++;
        if ((g >= lo && g <= hi) !== 1'b1) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got %h exp %h..%h", $time, g, lo, hi);
        end
    endtask : chk_rng

    task automatic ck(input int n);
        repeat (n) @(posedge clk);
    endtask : ck

    // Readies and answers are looked at mid-cycle, where they equal what
    // the next rising edge samples; right after that edge they race.
    task automatic wr(input logic [9:0] a, input logic [7:0] v);
        logic aw;
        logic w;
        logic ta;
        logic tw;
        logic tb;
        aw = 1'b1;
        w = 1'b1;
        @(posedge clk);
        rq.awvalid <= 1'b1;
        rq.awaddr <= a;
        rq.wvalid <= 1'b1;
        rq.wdata <= {24'h0, v};
        rq.wstrb <= 4'hf;
        rq.bready <= 1'b1;
        do begin
            @(negedge clk);
            ta = aw && rs.awready === 1'b1;
            tw = w && rs.wready === 1'b1;
            tb = rs.bvalid === 1'b1;
            if (tb) begin
                r = rs.bresp;
            end
            @(posedge clk);
            if (ta) begin
                aw = 1'b0;
                rq.awvalid <= 1'b0;
            end
            if (tw) begin
                w = 1'b0;
                rq.wvalid <= 1'b0;
            end
        end while (!tb);
        rq.bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [9:0] a);
        logic ta;
        logic tr;
        @(posedge clk);
        rq.arvalid <= 1'b1;
        rq.araddr <= a;
        rq.rready <= 1'b1;
        do begin
            @(negedge clk);
            ta = rs.arready === 1'b1;
            @(posedge clk);
        end while (!ta);
        rq.arvalid <= 1'b0;
        do begin
            @(negedge clk);
            tr = rs.rvalid === 1'b1;
            if (tr) begin
                d = rs.rdata;
                r = rs.rresp;
            end
            @(posedge clk);
        end while (!tr);
        rq.rready <= 1'b0;
    endtask : rd

    // Parks the count just below wrap with the given status, then runs.
    task automatic ovf(input logic [7:0] s);
        wr(AC, 8'h00);
        wr(AS, s);
        wr(AL, 8'hff);
        wr(AH, 8'hff);
        wr(AC, 8'h20);
        ck(40);
        rd(AS);
    endtask : ovf

    initial begin
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        rd(AC);
        chk(d, 32'h0);
        wr(AC, 8'hff);
        rd(AC);
        chk(d, 32'hfe);
        rd(10'h3fc);
        chk(r, RESP_SLVERR);
        wr(10'h3fc, 8'h01);
        chk(r, RESP_SLVERR);
        $display("test registers done");
        wr(AC, 8'h00);
        wr(AL, 8'h5a);
        wr(AH, 8'ha5);
        rd(AL);
        chk(d, 32'h5a);
        rd(AH);
        chk(d, 32'ha5);
        $display("test bytes done");
        for (int e = 0; e < 2; e++) begin
            wr(AC, (e != 0) ? 8'h40 : 8'h00);
            wr(AL, 8'h00);
            src.burst(20, 3);
            ck(10);
            rd(AL);
            chk(d, 32'd20);
        end
        wr(AC, 8'h44);
        wr(AL, 8'h00);
        src.burst(40, 2);
        ck(10);
        rd(AL);
        chk(d, 32'd10);
        $display("test pin done");
        // Eight prescaled ticks per window whatever the ratio.
        for (int i = 0; i < 10; i++) begin
            wr(AC, {2'b00, 1'b1, cd[i], 1'b0});
            wr(AL, 8'h00);
            ck(32 << ((i < 8) ? i : 8));
            rd(AL);
            chk_rng(d, 32'd6, 32'd9);
        end
        $display("test rates done");
        ovf(8'h31);
        chk(d & 32'h11, 32'h11);
        chk(irq, 32'h1);
        rd(AH);
        chk(d, 32'h0);
        @(posedge clk) ack <= 1'b1;
        @(posedge clk) ack <= 1'b0;
        ck(2);
        rd(AS);
        chk(d & 32'h10, 32'h0);
        chk(irq, 32'h0);
        ovf(8'h30);
        chk(d & 32'h11, 32'h10);
        chk(irq, 32'h0);
        $display("test overflow done");
        wr(AC, 8'h80);
        wr(AS, 8'h32);
        @(posedge clk) eirq <= 1'b1;
        ck(3);
        rd(AS);
        chk(d & 32'h20, 32'h20);
        chk(irq, 32'h1);
        wr(AS, 8'h22);
        @(posedge clk) eirq <= 1'b0;
        ck(3);
        rd(AS);
        chk(d & 32'h20, 32'h0);
        wr(AC, 8'h00);
        @(posedge clk) eirq <= 1'b1;
        ck(3);
        rd(AS);
        chk(d & 32'h20, 32'h0);
        @(posedge clk) eirq <= 1'b0;
        ck(3);
        rd(AS);
        chk(d & 32'h20, 32'h20);
        $display("test irq pin done");
        final_report();
    end
endmodule : test_prescaled_16bit_overflow_timer
